/* inc/twomc_map.vh */
// Register map, field positions and mode codes of the waveform output control block
`ifndef TWOMC_MAP_VH
`define TWOMC_MAP_VH

`define TWOMC_ADDR_CTRL_A 8'hb0
`define TWOMC_ADDR_CTRL_B 8'hb1
`define TWOMC_ADDR_COUNT 8'hb2
`define TWOMC_ADDR_CMP_A 8'hb3
`define TWOMC_ADDR_CMP_B 8'hb4
`define TWOMC_ADDR_STATUS 8'hb7

`define TWOMC_CHA_MODE 7:6
`define TWOMC_CHA_UPPER 7
`define TWOMC_CHB_MODE 5:4
`define TWOMC_CHB_UPPER 5
`define TWOMC_WAVE_LOW 1:0
`define TWOMC_CTRL_A_MASK 8'hf3

`define TWOMC_CTRL_B_FIELD 3:0
`define TWOMC_WAVE_HIGH_BIT 3
`define TWOMC_CLK_SEL 2:0
`define TWOMC_OVF_BIT 0

`define TWOMC_RESET_BYTE 8'h00
`define TWOMC_RESET_NIBBLE 4'h0
`define TWOMC_ZERO_NIBBLE 4'h0
`define TWOMC_ZERO_SEVEN 7'h00
`define TWOMC_BOTTOM 8'h00
`define TWOMC_MAX 8'hff
`define TWOMC_ONE 8'h01

`define TWOMC_WAVE_NORMAL 3'h0
`define TWOMC_WAVE_PHASE_FIX 3'h1
`define TWOMC_WAVE_CLR_MATCH 3'h2
`define TWOMC_WAVE_FAST_FIX 3'h3
`define TWOMC_WAVE_PHASE_VAR 3'h5
`define TWOMC_WAVE_FAST_VAR 3'h7

`define TWOMC_KIND_NONPWM 2'h0
`define TWOMC_KIND_FAST 2'h1
`define TWOMC_KIND_PHASE 2'h2
`define TWOMC_KIND_OFF 2'h3

`define TWOMC_MODE_OFF 2'h0
`define TWOMC_MODE_TOGGLE 2'h1
`define TWOMC_MODE_CLEAR 2'h2
`define TWOMC_MODE_SET 2'h3

`endif

/* rtl/twomc_chan.v */
// Compare output unit for one channel: waveform state and pin override
`timescale 1ns/100ps

`include "twomc_map.vh"

module twomc_chan #(
  parameter TOGGLE_IN_PWM = 1
) (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [1:0] out_mode_i,
  input wire [1:0] kind_i,
  input wire wave_high_i,
  input wire match_i,
  input wire bottom_i,
  input wire top_i,
  input wire down_i,
  input wire cmp_top_i,
  input wire port_i,
  output wire connect_o,
  output wire pin_o
);

  reg wave_reg;
  reg wave_next;
  reg connect_next;
  reg connect_reg;
  reg pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  always @* begin
    wave_next = wave_reg;
    connect_next = 1'b0;
    case (kind_i)
      `TWOMC_KIND_NONPWM: begin
        connect_next = (out_mode_i != `TWOMC_MODE_OFF);
        if (match_i) begin
          case (out_mode_i)
            `TWOMC_MODE_TOGGLE: wave_next = ~wave_reg; // see [R3] see [R10]
            `TWOMC_MODE_CLEAR: wave_next = 1'b0;
            `TWOMC_MODE_SET: wave_next = 1'b1;
            default: wave_next = wave_reg;
          endcase
        end
      end
      `TWOMC_KIND_FAST: begin
        if (out_mode_i[1]) begin
          connect_next = 1'b1;
          if (bottom_i) begin
            wave_next = ~out_mode_i[0]; // see [R4] see [R11]
          end else if (match_i && !cmp_top_i) begin
            wave_next = out_mode_i[0]; // see [R6]
          end
        end else if (out_mode_i == `TWOMC_MODE_TOGGLE && wave_high_i && TOGGLE_IN_PWM != 0) begin
          connect_next = 1'b1; // see [R5]
          if (match_i) begin
            wave_next = ~wave_reg;
          end
        end
      end
      `TWOMC_KIND_PHASE: begin
        if (out_mode_i[1]) begin
          connect_next = 1'b1;
          if (top_i && cmp_top_i) begin
            wave_next = ~out_mode_i[0]; // see [R8] see [R13]
          end else if (match_i && !cmp_top_i) begin
            wave_next = down_i ? ~out_mode_i[0] : out_mode_i[0]; // see [R7] see [R12]
          end
        end else if (out_mode_i == `TWOMC_MODE_TOGGLE && wave_high_i && TOGGLE_IN_PWM != 0) begin
          connect_next = 1'b1; // see [R5]
          if (match_i) begin
            wave_next = ~wave_reg;
          end
        end
      end
      default: begin
        connect_next = 1'b0; // see [R20]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wave_reg <= 1'b0;
      connect_reg <= 1'b0;
      pin_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
      connect_reg <= connect_next;
      pin_reg <= connect_next ? wave_next : port_i; // see [R1] see [R9]
    end
  end

  assign connect_o = connect_reg;
  assign pin_o = pin_reg;

endmodule

/* rtl/twomc_top.v */
// Timer waveform mode control: control registers, counter, compare buffers, pin drive
`timescale 1ns/100ps

`include "twomc_map.vh"

// Summary of operation
// [R1] Nonzero channel A mode bits 7:6 route waveform onto pin A, replacing port data.
// [R2] Software sets the pin direction to output; mode bits do not enable drivers.
// [R3] Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// [R4] Fast PWM channel A: 10 clears on match sets at bottom; 11 the inverse.
// [R5] PWM channel A mode 01: disconnected unless mode high bit set, then toggles.
// [R6] Fast PWM, compare A equals top with upper bit: match ignored, bottom action.
// [R7] Phase PWM channel A: 10 clears on up match, sets on down; 11 opposite.
// [R8] Phase PWM, compare A equals top with upper bit: match ignored, action at top.
// [R9] Nonzero channel B mode bits 5:4 drive waveform onto pin B.
// [R10] Non-PWM channel B: 00 off, 01 toggle, 10 clear, 11 set on match.
// [R11] Fast PWM channel B: 01 reserved; 10 clear match/set bottom; 11 inverse.
// [R12] Phase PWM channel B: 01 reserved; 10 clear up/set down; 11 opposite.
// [R13] Phase PWM, compare B equals top with upper bit: match ignored, action at top.
// [R14] Mode select is control B bit 3 above control A bits 1:0.
// [R15] Codes: 0 normal, 1 phase, 2 clear-on-match, 3 fast, 5 phase, 7 fast.
// [R16] Top is 0xFF in modes 0,1,3 and compare A in modes 2,5,7.
// [R17] Compare writes apply at once in 0/2, at top in phase, bottom in fast.
// [R18] Overflow flag at 0xFF in 0,2,3; at bottom in 1,5; at top in 7.
// [R19] Mode high bit lives in control B bit 3, reset to zero.
// [R20] Reserved channel B code and reserved mode codes keep pins disconnected.
// [R21] Control A bits 3:2 read zero, ignore writes; reset clears all bits.
module twomc_top (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  input wire port_a_i,
  input wire port_b_i,
  output wire compare_pin_a_o,
  output wire compare_pin_b_o,
  output wire compare_pin_a_en_o,
  output wire compare_pin_b_en_o,
  output wire overflow_flag_o
);

  reg [7:0] waveform_control_a_reg;
  reg [3:0] waveform_control_b_reg;
  reg [7:0] count_reg;
  reg [7:0] count_next;
  reg dir_down_reg;
  reg dir_down_next;
  reg [7:0] cmp_a_buf_reg;
  reg [7:0] cmp_a_buf_next;
  reg [7:0] cmp_b_buf_reg;
  reg [7:0] cmp_b_buf_next;
  reg [7:0] compare_value_a_reg;
  reg [7:0] compare_value_b_reg;
  reg overflow_flag_reg;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;

  reg [1:0] kind;
  reg top_from_cmp;
  reg ovf_event;
  reg load_cmp;

  wire [2:0] waveform_mode_select;
  wire waveform_mode_high;
  wire run;
  wire [7:0] top_value;
  wire at_top;
  wire at_bottom;
  wire match_a;
  wire match_b;
  wire wrap_bottom;
  wire phase_top;
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire wr_count;
  wire wr_cmp_a;
  wire wr_cmp_b;
  wire wr_status;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  assign wr_ctrl_a = reg_wr_i && (reg_addr_i == `TWOMC_ADDR_CTRL_A);
  assign wr_ctrl_b = reg_wr_i && (reg_addr_i == `TWOMC_ADDR_CTRL_B);
  assign wr_count = reg_wr_i && (reg_addr_i == `TWOMC_ADDR_COUNT);
  assign wr_cmp_a = reg_wr_i && (reg_addr_i == `TWOMC_ADDR_CMP_A);
  assign wr_cmp_b = reg_wr_i && (reg_addr_i == `TWOMC_ADDR_CMP_B);
  assign wr_status = reg_wr_i && (reg_addr_i == `TWOMC_ADDR_STATUS);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waveform_control_a_reg <= `TWOMC_RESET_BYTE; // see [R21]
      waveform_control_b_reg <= `TWOMC_RESET_NIBBLE; // see [R19]
    end else begin
      if (wr_ctrl_a) begin
        waveform_control_a_reg <= reg_wdata_i & `TWOMC_CTRL_A_MASK; // see [R21]
      end
      if (wr_ctrl_b) begin
        waveform_control_b_reg <= reg_wdata_i[`TWOMC_CTRL_B_FIELD];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode

  assign waveform_mode_high = waveform_control_b_reg[`TWOMC_WAVE_HIGH_BIT];
  assign waveform_mode_select = {waveform_mode_high, waveform_control_a_reg[`TWOMC_WAVE_LOW]}; // see [R14]
  // Prescaler is not modelled: any nonzero clock select runs at the core rate
  assign run = (waveform_control_b_reg[`TWOMC_CLK_SEL] != 3'h0);

  always @* begin
    kind = `TWOMC_KIND_OFF;
    top_from_cmp = 1'b0;
    case (waveform_mode_select) // see [R15]
      `TWOMC_WAVE_NORMAL: begin
        kind = `TWOMC_KIND_NONPWM;
      end
      `TWOMC_WAVE_PHASE_FIX: begin
        kind = `TWOMC_KIND_PHASE;
      end
      `TWOMC_WAVE_CLR_MATCH: begin
        kind = `TWOMC_KIND_NONPWM;
        top_from_cmp = 1'b1; // see [R16]
      end
      `TWOMC_WAVE_FAST_FIX: begin
        kind = `TWOMC_KIND_FAST;
      end
      `TWOMC_WAVE_PHASE_VAR: begin
        kind = `TWOMC_KIND_PHASE;
        top_from_cmp = 1'b1;
      end
      `TWOMC_WAVE_FAST_VAR: begin
        kind = `TWOMC_KIND_FAST;
        top_from_cmp = 1'b1;
      end
      default: begin
        // Reserved codes count like normal mode but drive no pin
        kind = `TWOMC_KIND_OFF; // see [R20]
      end
    endcase
  end

  assign top_value = top_from_cmp ? compare_value_a_reg : `TWOMC_MAX; // see [R16]
  assign at_top = (count_reg == top_value);
  assign at_bottom = (count_reg == `TWOMC_BOTTOM);

  ////////////////////////////////////////////////////////////////////////////
  // Counter; outputs react one clock after the count value that caused them

  always @* begin
    count_next = count_reg;
    dir_down_next = 1'b0;
    if (wr_count) begin
      count_next = reg_wdata_i;
      dir_down_next = dir_down_reg && (kind == `TWOMC_KIND_PHASE);
    end else if (run) begin
      if (kind == `TWOMC_KIND_PHASE) begin
        dir_down_next = dir_down_reg;
        if (!dir_down_reg && at_top) begin
          dir_down_next = 1'b1;
          count_next = at_bottom ? count_reg : count_reg - `TWOMC_ONE;
        end else if (dir_down_reg && at_bottom) begin
          dir_down_next = 1'b0;
          count_next = at_top ? count_reg : count_reg + `TWOMC_ONE;
        end else if (dir_down_reg) begin
          count_next = count_reg - `TWOMC_ONE;
        end else begin
          count_next = count_reg + `TWOMC_ONE;
        end
      end else begin
        count_next = at_top ? `TWOMC_BOTTOM : count_reg + `TWOMC_ONE;
      end
    end else begin
      dir_down_next = dir_down_reg && (kind == `TWOMC_KIND_PHASE);
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_reg <= `TWOMC_RESET_BYTE;
      dir_down_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      dir_down_reg <= dir_down_next;
    end
  end

  assign wrap_bottom = run && at_top && (kind == `TWOMC_KIND_FAST);
  assign phase_top = run && at_top && !dir_down_reg && (kind == `TWOMC_KIND_PHASE);
  assign match_a = run && (count_reg == compare_value_a_reg);
  assign match_b = run && (count_reg == compare_value_b_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Compare buffers: software sees the buffer, the compare uses the active copy

  always @* begin
    cmp_a_buf_next = cmp_a_buf_reg;
    cmp_b_buf_next = cmp_b_buf_reg;
    if (wr_cmp_a) begin
      cmp_a_buf_next = reg_wdata_i;
    end
    if (wr_cmp_b) begin
      cmp_b_buf_next = reg_wdata_i;
    end
  end

  always @* begin
    case (kind) // see [R17]
      `TWOMC_KIND_PHASE: load_cmp = phase_top;
      `TWOMC_KIND_FAST: load_cmp = wrap_bottom;
      default: load_cmp = 1'b1;
    endcase
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmp_a_buf_reg <= `TWOMC_RESET_BYTE;
      cmp_b_buf_reg <= `TWOMC_RESET_BYTE;
      compare_value_a_reg <= `TWOMC_RESET_BYTE;
      compare_value_b_reg <= `TWOMC_RESET_BYTE;
    end else begin
      cmp_a_buf_reg <= cmp_a_buf_next;
      cmp_b_buf_reg <= cmp_b_buf_next;
      if (load_cmp) begin
        compare_value_a_reg <= cmp_a_buf_next; // see [R17]
        compare_value_b_reg <= cmp_b_buf_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overflow flag; a set in the clearing cycle wins

  always @* begin
    case (waveform_mode_select) // see [R18]
      `TWOMC_WAVE_NORMAL: ovf_event = run && (count_reg == `TWOMC_MAX);
      `TWOMC_WAVE_CLR_MATCH: ovf_event = run && (count_reg == `TWOMC_MAX);
      `TWOMC_WAVE_FAST_FIX: ovf_event = run && (count_reg == `TWOMC_MAX);
      `TWOMC_WAVE_PHASE_FIX: ovf_event = run && at_bottom && dir_down_reg;
      `TWOMC_WAVE_PHASE_VAR: ovf_event = run && at_bottom && dir_down_reg;
      `TWOMC_WAVE_FAST_VAR: ovf_event = run && at_top;
      default: ovf_event = 1'b0;
    endcase
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      overflow_flag_reg <= 1'b0;
    end else if (ovf_event) begin
      overflow_flag_reg <= 1'b1; // see [R18]
    end else if (wr_status && reg_wdata_i[`TWOMC_OVF_BIT]) begin
      overflow_flag_reg <= 1'b0;
    end
  end

  assign overflow_flag_o = overflow_flag_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe, zero otherwise

  always @* begin
    rdata_next = `TWOMC_RESET_BYTE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `TWOMC_ADDR_CTRL_A: rdata_next = waveform_control_a_reg; // see [R21]
        `TWOMC_ADDR_CTRL_B: rdata_next = {`TWOMC_ZERO_NIBBLE, waveform_control_b_reg};
        `TWOMC_ADDR_COUNT: rdata_next = count_reg;
        `TWOMC_ADDR_CMP_A: rdata_next = cmp_a_buf_reg;
        `TWOMC_ADDR_CMP_B: rdata_next = cmp_b_buf_reg;
        `TWOMC_ADDR_STATUS: rdata_next = {`TWOMC_ZERO_SEVEN, overflow_flag_reg};
        default: rdata_next = `TWOMC_RESET_BYTE;
      endcase
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= `TWOMC_RESET_BYTE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Compare output units; driver enable stays with the port direction logic

  twomc_chan #(
    .TOGGLE_IN_PWM(1)
  ) u_chan_a (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .out_mode_i(waveform_control_a_reg[`TWOMC_CHA_MODE]), // see [R1]
    .kind_i(kind),
    .wave_high_i(waveform_mode_high),
    .match_i(match_a),
    .bottom_i(wrap_bottom),
    .top_i(phase_top),
    .down_i(dir_down_reg),
    .cmp_top_i(waveform_control_a_reg[`TWOMC_CHA_UPPER] && (compare_value_a_reg == top_value)),
    .port_i(port_a_i),
    .connect_o(compare_pin_a_en_o),
    .pin_o(compare_pin_a_o)
  );

  // Channel B has no toggle in PWM; its 01 code is reserved and stays off
  twomc_chan #(
    .TOGGLE_IN_PWM(0)
  ) u_chan_b (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .out_mode_i(waveform_control_a_reg[`TWOMC_CHB_MODE]), // see [R9]
    .kind_i(kind),
    .wave_high_i(waveform_mode_high),
    .match_i(match_b),
    .bottom_i(wrap_bottom),
    .top_i(phase_top),
    .down_i(dir_down_reg),
    .cmp_top_i(waveform_control_a_reg[`TWOMC_CHB_UPPER] && (compare_value_b_reg == top_value)), // see [R13]
    .port_i(port_b_i),
    .connect_o(compare_pin_b_en_o),
    .pin_o(compare_pin_b_o)
  );

endmodule

/* tb/twomc_checker.sv */
// Port-level assertions for the waveform output control block
`timescale 1ns/100ps
module twomc_checker (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire port_a_i,
  input wire port_b_i,
  input wire compare_pin_a_o,
  input wire compare_pin_b_o,
  input wire compare_pin_a_en_o,
  input wire compare_pin_b_en_o,
  input wire overflow_flag_o
);
  wire ctrl_wr = reg_wr_i && (reg_addr_i == 8'hb0 || reg_addr_i == 8'hb1);
  wire flag_clr = reg_wr_i && reg_addr_i == 8'hb7 && reg_wdata_i[0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////
  ctrl_unused_a: assert property (reg_rd_i && reg_addr_i == 8'hb0 |=> reg_rdata_o[3:2] == 2'b00)
    else $error("control bits 3:2 read nonzero");
  pin_a_port_a: assert property ($past(resetn_i) && !compare_pin_a_en_o && !$past(compare_pin_a_en_o)
    |-> compare_pin_a_o == $past(port_a_i)) else $error("pin a not following port");
  pin_b_port_a: assert property ($past(resetn_i) && !compare_pin_b_en_o && !$past(compare_pin_b_en_o)
    |-> compare_pin_b_o == $past(port_b_i)) else $error("pin b not following port");
  pin_a_release_a: assert property (reg_wr_i && reg_addr_i == 8'hb0 && reg_wdata_i[7:6] == 2'b00
    |-> ##[1:2] !compare_pin_a_en_o) else $error("pin a still owned");
  pin_b_release_a: assert property (reg_wr_i && reg_addr_i == 8'hb0 && reg_wdata_i[5:4] == 2'b00
    |-> ##[1:2] !compare_pin_b_en_o) else $error("pin b still owned");
  pin_a_claim_a: assert property ($rose(compare_pin_a_en_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("pin a claimed without control write");
  pin_b_claim_a: assert property ($rose(compare_pin_b_en_o) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("pin b claimed without control write");
  flag_clear_a: assert property ($fell(overflow_flag_o) |-> $past(flag_clr))
    else $error("overflow flag dropped without clear");
endmodule

bind twomc_top twomc_checker i_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .port_a_i(port_a_i), .port_b_i(port_b_i), .compare_pin_a_o(compare_pin_a_o), .compare_pin_b_o(compare_pin_b_o),
  .compare_pin_a_en_o(compare_pin_a_en_o), .compare_pin_b_en_o(compare_pin_b_en_o),
  .overflow_flag_o(overflow_flag_o));

/* tb/twomc_pin_load.sv */
// Load on one compare pin: pulled-up line and a count of cycles spent high
`timescale 1ns/100ps
module twomc_pin_load (
  input wire core_clk_i,
  input wire dir_i,
  input wire pin_i,
  input wire clr_i,
  output wire line_o,
  output logic [9:0] high_cnt_o
);
  // Mode bits alone never drive the line; an undriven line floats to the pull-up
  assign line_o = dir_i ? pin_i : 1'b1;
  always @(posedge core_clk_i) begin
    if (clr_i) begin
      high_cnt_o <= 10'h000;
    end else if (line_o) begin
      high_cnt_o <= high_cnt_o + 10'h001;
    end
  end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the waveform output control block
`timescale 1ns/100ps
module testbench;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0, rd = 1'b0, port_a = 1'b0, port_b = 1'b0, dir = 1'b0, clr = 1'b0;
  wire [7:0] rdata_o;
  wire pin_a, pin_b, en_a, en_b, ovf, line_a, line_b;
  wire [9:0] cnt_a, cnt_b;
  int mismatches = 0;
  int checks = 0;

  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    {port_a, port_b} <= 2'($urandom);
  end

  twomc_top i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata_o), .port_a_i(port_a), .port_b_i(port_b),
    .compare_pin_a_o(pin_a), .compare_pin_b_o(pin_b), .compare_pin_a_en_o(en_a),
    .compare_pin_b_en_o(en_b), .overflow_flag_o(ovf));
  twomc_pin_load i_load_a (.core_clk_i(core_clk_i), .dir_i(dir), .pin_i(pin_a), .clr_i(clr),
    .line_o(line_a), .high_cnt_o(cnt_a));
  twomc_pin_load i_load_b (.core_clk_i(core_clk_i), .dir_i(dir), .pin_i(pin_b), .clr_i(clr),
    .line_o(line_b), .high_cnt_o(cnt_b));

  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk_i);
    rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Compares are loaded in normal mode while stopped so they act at once
  task automatic run(input logic [7:0] ctrl, input logic wh, input logic [7:0] ca, input logic [7:0] cb,
    input logic [7:0] start);
    wr_reg(8'hb1, 8'h00);
    wr_reg(8'hb0, 8'h00);
    wr_reg(8'hb3, ca);
    wr_reg(8'hb4, cb);
    wr_reg(8'hb0, ctrl);
    wr_reg(8'hb2, start);
    wr_reg(8'hb7, 8'h01);
    wr_reg(8'hb1, {4'h0, wh, 3'b001});
  endtask

  // Warm-up lets the pin waveforms settle before high cycles are counted
  task automatic measure(input int p);
    repeat (1100) @(posedge core_clk_i);
    clr <= 1'b1;
    @(posedge core_clk_i);
    clr <= 1'b0;
    repeat (p) @(posedge core_clk_i);
    #1;
  endtask

  function automatic logic [9:0] duty(input logic fast, input logic inv, input logic [7:0] c);
    if (fast) return inv ? 10'(8'hff - c) : 10'(c) + 10'h001;
    return inv ? 10'h1fe - 10'(c) * 2 : 10'(c) * 2;
  endfunction

  ////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, ca, cb, t;
    logic fast, inv, pa, pb;
    void'($urandom(45762));
    repeat (12) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rd_reg(8'hb0, d);
    chk("ctrl a reset", 10'h000, 10'(d));
    rd_reg(8'hb1, d);
    chk("ctrl b reset", 10'h000, 10'(d));
    t = 8'($urandom);
    wr_reg(8'hb0, t);
    rd_reg(8'hb0, d);
    chk("ctrl a readback", 10'(t & 8'hf3), 10'(d));
    rd_reg(8'hb5, d);
    chk("unmapped read", 10'h000, 10'(d));
    for (int m = 0; m < 4; m++) begin
      run(8'(m * 8'h50), 1'b0, 8'($urandom_range(200, 4)), 8'($urandom_range(200, 4)), 8'h00);
      #1;
      pa = pin_a;
      pb = pin_b;
      repeat (210) @(posedge core_clk_i);
      #1;
      chk("pin a owned", 10'(m != 0), 10'(en_a));
      chk("pin b owned", 10'(m != 0), 10'(en_b));
      if (m != 0) begin
        chk("pin a level", 10'(m == 1 ? !pa : m == 3), 10'(pin_a));
        chk("pin b level", 10'(m == 1 ? !pb : m == 3), 10'(pin_b));
      end
    end
    dir <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      fast = i[0];
      inv = i[1];
      ca = 8'($urandom_range(254, 1));
      cb = 8'($urandom_range(254, 1));
      if (fast && i < 4) ca = inv ? 8'hff : 8'h00;
      run({1'b1, inv, 1'b1, inv, 2'b00, fast, 1'b1}, 1'b0, ca, cb, 8'h00);
      measure(fast ? 256 : 510);
      chk("duty a", duty(fast, inv, ca), cnt_a);
      chk("duty b", duty(fast, inv, cb), cnt_b);
    end
    for (int j = 0; j < 2; j++) begin
      run(j ? 8'h53 : 8'h51, 1'b0, 8'h40, 8'h40, 8'h00);
      repeat (20) @(posedge core_clk_i);
      #1;
      chk("reserved pin a", 10'h000, 10'(en_a));
      chk("reserved pin b", 10'h000, 10'(en_b));
    end
    t = 8'($urandom_range(120, 10));
    cb = 8'($urandom_range(int'(t) - 1, 1));
    run(8'h63, 1'b1, t, cb, 8'h00);
    measure(2 * (int'(t) + 1));
    chk("toggle a", 10'(t) + 10'h001, cnt_a);
    chk("top b", 10'(cb) * 2 + 10'h002, cnt_b);
    for (int m = 0; m < 8; m++) begin
      run({6'b101000, 2'(m)}, 1'(m >> 2), 8'h80, 8'h80, (m == 2 || m == 5 || m == 7) ? 8'h70 : 8'hf0);
      repeat (40) @(posedge core_clk_i);
      #1;
      chk("overflow flag", 10'(m == 0 || m == 3 || m == 7), 10'(ovf));
      chk("mode pin a", 10'(m != 4 && m != 6), 10'(en_a));
    end
    close_out();
  end

  initial begin
    repeat (60000) @(posedge core_clk_i);
    mismatches++;
    close_out();
  end
endmodule
